/* File: hdl/dsr_link_if.sv */
// Pin-level link between the memory controller and the burst SRAM
`timescale 1ns/1ps
`default_nettype none
interface dsr_link_if #(
  parameter int DW = dsr_pkg::DATA_W,
  parameter int AW = dsr_pkg::ADDR_W,
  parameter int NB = dsr_pkg::LANES
) ();
  logic          pos_phase;
  logic [AW-1:0] addr;
  logic          write_port_select_n;
  logic          read_port_select_n;
  logic [NB-1:0] byte_write_mask_n;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] rd_data;
  logic          rd_data_oe_n;
  logic          read_valid_flag;
  logic          echo_clock_out;

  modport device (
    input  pos_phase, addr, write_port_select_n, read_port_select_n,
    input  byte_write_mask_n, wr_data,
    output rd_data, rd_data_oe_n, read_valid_flag, echo_clock_out
  );
  modport ctrl (
    output pos_phase, addr, write_port_select_n, read_port_select_n,
    output byte_write_mask_n, wr_data,
    input  rd_data, rd_data_oe_n, read_valid_flag, echo_clock_out
  );
endinterface : dsr_link_if
`default_nettype wire

/* File: hdl/dsr_pkg.sv */
// Shared constants for the burst SRAM link: widths, phases, beat counts
package dsr_pkg;
  // Default geometry: 36-bit words, 19-bit burst address, 4 write lanes
  localparam int DATA_W     = 36;
  localparam int ADDR_W     = 19;
  localparam int LANES      = 4;
  localparam int BURST_LEN  = 4;
  localparam int FIFO_DEPTH = 2;

  // Clock phases: even phases are positive-clock edges, odd ones negative
  localparam logic [1:0] PH_RD_SLOT  = 2'h0;
  localparam logic [1:0] PH_WR_READY = 2'h1;
  localparam logic [1:0] PH_WR_SLOT  = 2'h2;
  localparam logic [1:0] PH_RD_READY = 2'h3;
  localparam logic [1:0] PH_RESET    = 2'h3;

  // Beat counters
  localparam logic [1:0] BEAT_FIRST  = 2'h0;
  localparam logic [1:0] BEAT_SECOND = 2'h1;
  localparam logic [1:0] BEAT_LAST   = 2'h3;
  localparam logic [2:0] BEATS_ALL   = 3'h4;
endpackage : dsr_pkg

/* File: hdl/dsr_sram_ctl.sv */
// Memory controller end: issues bursts, buffers read bursts for the user
`timescale 1ns/1ps
`default_nettype none
module dsr_sram_ctl #(
  parameter int DW    = dsr_pkg::DATA_W,
  parameter int AW    = dsr_pkg::ADDR_W,
  parameter int NB    = dsr_pkg::LANES,
  parameter int DEPTH = dsr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // Link
  dsr_link_if.ctrl             lnk,
  // Write burst request
  input  wire logic            i_wr_valid,
  input  wire logic [AW-1:0]   i_wr_addr,
  input  wire logic [4*DW-1:0] i_wr_data,
  input  wire logic [4*NB-1:0] i_wr_mask_n,
  output logic                 o_wr_ready,
  // Read burst request
  input  wire logic            i_rd_valid,
  input  wire logic [AW-1:0]   i_rd_addr,
  output logic                 o_rd_ready,
  // Read burst data
  output logic                 o_rdq_valid,
  output logic [4*DW-1:0]      o_rdq_data,
  input  wire logic            i_rdq_ready
);
  localparam int BW = 4 * DW;
  localparam int FW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [1:0]              ph;
    logic                    pos;
    logic [AW-1:0]           addr;
    logic                    wsel_n;
    logic                    rsel_n;
    logic [NB-1:0]           mask_n;
    logic [DW-1:0]           wd;
    logic [BW-1:0]           wbuf;
    logic [4*NB-1:0]         wmbuf;
    logic [2:0]              wleft;
    logic                    wr_rdy;
    logic                    rd_rdy;
    logic [1:0]              outst;
    logic [BW-1:0]           cap;
    logic [1:0]              ccnt;
    logic [DEPTH-1:0][BW-1:0] fifo;
    logic [FW-1:0]           fcnt;
    logic                    fvld;
  } dsr_ctl_st_t;

  dsr_ctl_st_t st_ff;
  dsr_ctl_st_t nxt_st;

  always_comb begin
    int unsigned wp;
    logic        push;
    logic        pop;
    wp     = 0;
    push   = 1'b0;
    pop    = 1'b0;
    nxt_st = st_ff;
    nxt_st.ph     = st_ff.ph + 2'h1;
    nxt_st.pos    = ~nxt_st.ph[0];
    nxt_st.wsel_n = 1'b1;
    nxt_st.rsel_n = 1'b1;
    nxt_st.mask_n = '1;
    nxt_st.wd     = '0;
    // Write beats drain every edge; last beat may share a new select
    if (st_ff.wleft != 3'h0) begin
      nxt_st.wd     = st_ff.wbuf[DW-1:0];
      nxt_st.mask_n = st_ff.wmbuf[NB-1:0];
      nxt_st.wbuf   = st_ff.wbuf >> DW;
      nxt_st.wmbuf  = st_ff.wmbuf >> NB;
      nxt_st.wleft  = st_ff.wleft - 3'h1;
    end
    // Write burst: select on a write slot, beats on the next four edges
    if (st_ff.wr_rdy && i_wr_valid) begin
      nxt_st.wsel_n = 1'b0;
      nxt_st.addr   = i_wr_addr;
      nxt_st.wbuf   = i_wr_data;
      nxt_st.wmbuf  = i_wr_mask_n;
      nxt_st.wleft  = dsr_pkg::BEATS_ALL;
    end
    // Read burst: select on the alternate positive edge
    if (st_ff.rd_rdy && i_rd_valid) begin
      nxt_st.rsel_n = 1'b0;
      nxt_st.addr   = i_rd_addr;
      nxt_st.outst  = nxt_st.outst + 2'h1;
    end
    // Capture read beats, first beat lands in the low word
    if (lnk.read_valid_flag) begin
      nxt_st.cap  = {lnk.rd_data, st_ff.cap[BW-1:DW]};
      nxt_st.ccnt = st_ff.ccnt + 2'h1;
      if (st_ff.ccnt == dsr_pkg::BEAT_LAST) begin
        push         = 1'b1;
        nxt_st.outst = nxt_st.outst - 2'h1;
      end
    end
    // Two-entry burst buffer, head always in entry zero
    pop = st_ff.fvld && i_rdq_ready;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt_st.fifo[i] = st_ff.fifo[i+1];
      end
      nxt_st.fcnt = st_ff.fcnt - FW'(1);
    end
    if (push) begin
      wp = 32'(nxt_st.fcnt);
      nxt_st.fifo[wp] = nxt_st.cap;
      nxt_st.fcnt     = nxt_st.fcnt + FW'(1);
    end
    nxt_st.fvld   = nxt_st.fcnt != '0;
    nxt_st.wr_rdy = nxt_st.ph == dsr_pkg::PH_WR_READY;
    nxt_st.rd_rdy = (nxt_st.ph == dsr_pkg::PH_RD_READY) &&
                    (32'(nxt_st.fcnt) + 32'(nxt_st.outst) < DEPTH);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff        <= '0;
      st_ff.ph     <= dsr_pkg::PH_RESET;
      st_ff.wsel_n <= 1'b1;
      st_ff.rsel_n <= 1'b1;
      st_ff.mask_n <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.pos_phase           = st_ff.pos;
  assign lnk.addr                = st_ff.addr;
  assign lnk.write_port_select_n = st_ff.wsel_n;
  assign lnk.read_port_select_n  = st_ff.rsel_n;
  assign lnk.byte_write_mask_n   = st_ff.mask_n;
  assign lnk.wr_data             = st_ff.wd;
  assign o_wr_ready              = st_ff.wr_rdy;
  assign o_rd_ready              = st_ff.rd_rdy;
  assign o_rdq_valid             = st_ff.fvld;
  assign o_rdq_data              = st_ff.fifo[0];
endmodule : dsr_sram_ctl
`default_nettype wire

/* File: hdl/dsr_sram_dev.sv */
// Burst SRAM device end: write port with lane masks, read port, array
`timescale 1ns/1ps
`default_nettype none
module dsr_sram_dev #(
  parameter int DW = dsr_pkg::DATA_W,
  parameter int AW = dsr_pkg::ADDR_W,
  parameter int NB = dsr_pkg::LANES
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Link
  dsr_link_if.device lnk,
  // Status
  output logic      o_wr_busy,
  output logic      o_rd_busy,
  output logic      o_wr_beat,
  output logic      o_sel_ignored
);
  // Lane width: 4 for the 8-bit part (nibbles), 9 otherwise
  localparam int LW    = DW / NB;
  localparam int DEPTH = 1 << (AW + 2);
  localparam int IW    = AW + 2;

  typedef struct packed {
    logic          wact;
    logic [1:0]    wcnt;
    logic [AW-1:0] waddr;
    logic          ract;
    logic [1:0]    rcnt;
    logic [AW-1:0] raddr;
    logic [DW-1:0] q;
    logic          oe_n;
    logic          vld;
    logic          echo;
    logic          wbeat;
    logic          ign;
  } dsr_dev_st_t;

  dsr_dev_st_t   st_ff;
  dsr_dev_st_t   nxt_st;
  logic [DW-1:0] mem [DEPTH];
  logic          wr_en;
  logic [IW-1:0] wr_idx;
  logic [DW-1:0] wr_word;

  // Array index of one beat within a burst location
  function automatic logic [IW-1:0] beat_idx(input logic [AW-1:0] a,
                                             input logic [1:0]    b);
    beat_idx = {a, b};
  endfunction : beat_idx

  // Replace only the lanes whose mask is low
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
                                               input logic [DW-1:0] new_w,
                                               input logic [NB-1:0] msk_n);
    lane_merge = old_w;
    for (int i = 0; i < NB; i++) begin
      if (!msk_n[i]) begin
        lane_merge[i*LW +: LW] = new_w[i*LW +: LW];
      end
    end
  endfunction : lane_merge

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.wbeat = 1'b0;
    nxt_st.ign   = 1'b0;
    nxt_st.echo  = lnk.pos_phase;
    wr_en        = 1'b0;
    wr_idx       = beat_idx(st_ff.waddr, st_ff.wcnt);
    wr_word      = '0;

    // Write beats: one per edge, mask sampled with the same beat
    if (st_ff.wact) begin
      wr_en        = 1'b1;
      wr_word      = lane_merge(mem[wr_idx], lnk.wr_data, lnk.byte_write_mask_n);
      nxt_st.wcnt  = st_ff.wcnt + 2'h1;
      nxt_st.wbeat = 1'b1;
      if (st_ff.wcnt == dsr_pkg::BEAT_LAST) begin
        nxt_st.wact = 1'b0;
      end
    end
    // Write select only on a positive edge; deselect leaves data unused
    if (lnk.pos_phase && !lnk.write_port_select_n) begin
      if (!st_ff.wact || st_ff.wcnt == dsr_pkg::BEAT_LAST) begin
        nxt_st.wact  = 1'b1;
        nxt_st.wcnt  = dsr_pkg::BEAT_FIRST;
        nxt_st.waddr = lnk.addr;
      end else begin
        nxt_st.ign = 1'b1;
      end
    end

    // Read beats: outputs float unless a burst is running
    nxt_st.q    = '0;
    nxt_st.oe_n = 1'b1;
    nxt_st.vld  = 1'b0;
    if (st_ff.ract) begin
      nxt_st.q    = mem[beat_idx(st_ff.raddr, st_ff.rcnt)];
      nxt_st.oe_n = 1'b0;
      nxt_st.vld  = 1'b1;
      nxt_st.rcnt = st_ff.rcnt + 2'h1;
      if (st_ff.rcnt == dsr_pkg::BEAT_LAST) begin
        nxt_st.ract = 1'b0;
      end
    end
    if (lnk.pos_phase && !lnk.read_port_select_n) begin
      if (!st_ff.ract) begin
        nxt_st.ract  = 1'b1;
        nxt_st.raddr = lnk.addr;
        nxt_st.rcnt  = dsr_pkg::BEAT_SECOND;
        nxt_st.q     = mem[beat_idx(lnk.addr, dsr_pkg::BEAT_FIRST)];
        nxt_st.oe_n  = 1'b0;
        nxt_st.vld   = 1'b1;
      end else begin
        nxt_st.ign = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff      <= '0;
      st_ff.oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      if (wr_en) begin
        mem[wr_idx] <= wr_word;
      end
    end
  end

  // Address and data widths follow the parameters (19/20/21, 36/18/9/8)
  assign lnk.rd_data         = st_ff.q;
  assign lnk.rd_data_oe_n    = st_ff.oe_n;
  assign lnk.read_valid_flag = st_ff.vld;
  assign lnk.echo_clock_out  = st_ff.echo;
  assign o_wr_busy           = st_ff.wact;
  assign o_rd_busy           = st_ff.ract;
  assign o_wr_beat           = st_ff.wbeat;
  assign o_sel_ignored       = st_ff.ign;
endmodule : dsr_sram_dev
`default_nettype wire

/* File: tb/dsr_link_props.sv */
// Link protocol checks between controller and SRAM ends
`timescale 1ns/1ps
`default_nettype none
module dsr_link_props #(
  parameter int DW = 36,
  parameter int AW = 19,
  parameter int NB = 4
) (
  // Clock and reset
  input wire logic          i_clk,
  input wire logic          i_rst_n,
  // Link signals
  input wire logic          pos_phase,
  input wire logic [AW-1:0] addr,
  input wire logic          write_port_select_n,
  input wire logic          read_port_select_n,
  input wire logic [NB-1:0] byte_write_mask_n,
  input wire logic [DW-1:0] wr_data,
  input wire logic [DW-1:0] rd_data,
  input wire logic          rd_data_oe_n,
  input wire logic          read_valid_flag,
  input wire logic          echo_clock_out
);
  logic [2:0] beat_cnt_ff;
  logic [2:0] nxt_beat_cnt;

  // Write beats left after a select
  always_comb begin
    nxt_beat_cnt = (beat_cnt_ff != 3'h0) ? beat_cnt_ff - 3'h1 : 3'h0;
    if (!write_port_select_n) begin
      nxt_beat_cnt = 3'h4;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      beat_cnt_ff <= 3'h0;
    end else begin
      beat_cnt_ff <= nxt_beat_cnt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_both_edges;
    !pos_phase ##1 pos_phase ##1 !pos_phase ##1 pos_phase;
  endsequence
  sequence s_rd_beats;
    (read_valid_flag && !rd_data_oe_n)[*4];
  endsequence

  a_wsel_k_edge: assert property (!write_port_select_n |-> pos_phase)
    else $error("write select off K edge");
  a_rsel_k_edge: assert property (!read_port_select_n |-> pos_phase)
    else $error("read select off K edge");
  a_wr_both_edges: assert property (!write_port_select_n |=> s_both_edges)
    else $error("write beats not on both edges");
  a_mask_in_beats: assert property (byte_write_mask_n != '1 |-> beat_cnt_ff != 3'h0)
    else $error("mask active outside beats");
  a_data_in_beats: assert property (beat_cnt_ff == 3'h0 |-> wr_data == '0)
    else $error("write data outside beats");
  a_rd_four_beats: assert property (!read_port_select_n |=> s_rd_beats)
    else $error("read burst not four beats");
  a_rd_float_idle: assert property (!read_valid_flag |-> rd_data_oe_n && rd_data == '0)
    else $error("read bus driven when idle");
  a_valid_after_sel: assert property ($rose(read_valid_flag) |-> !$past(read_port_select_n))
    else $error("read data without select");
  a_echo_aligned: assert property ($past(i_rst_n) |-> echo_clock_out == $past(pos_phase))
    else $error("echo clock misaligned");
  a_slots_apart: assert property (!write_port_select_n |-> read_port_select_n ##1
    (read_port_select_n && write_port_select_n) ##1 write_port_select_n)
    else $error("read and write slots collide");
endmodule : dsr_link_props
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench: controller and SRAM ends joined over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t mismatch", $time); end end
module testbench;
  localparam int DW = 36;
  localparam int AW = 6;
  localparam int NB = 4;
  localparam int BW = 4 * DW;
  logic            i_clk       = 1'b0;
  logic            i_rst_n     = 1'b0;
  logic            i_wr_valid  = 1'b0;
  logic [AW-1:0]   i_wr_addr   = '0;
  logic [BW-1:0]   i_wr_data   = '0;
  logic [4*NB-1:0] i_wr_mask_n = '1;
  logic            o_wr_ready;
  logic            i_rd_valid  = 1'b0;
  logic [AW-1:0]   i_rd_addr   = '0;
  logic            o_rd_ready;
  logic            o_rdq_valid;
  logic [BW-1:0]   o_rdq_data;
  logic            i_rdq_ready = 1'b0;
  logic            o_wr_busy;
  logic            o_rd_busy;
  logic            o_wr_beat;
  logic            o_sel_ignored;
  wire  [DW-1:0]   rd_pins;
  int              error_cnt   = 0;
  int              cmp_count   = 0;
  logic [BW-1:0]   shadow [int];

  always #4 i_clk = ~i_clk;

  dsr_link_if #(.DW(DW), .AW(AW), .NB(NB)) lnk ();
  dsr_sram_ctl #(.DW(DW), .AW(AW), .NB(NB), .DEPTH(2)) u_dsr_sram_ctl (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .lnk(lnk), .i_wr_valid(i_wr_valid), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_wr_mask_n(i_wr_mask_n),
    .o_wr_ready(o_wr_ready), .i_rd_valid(i_rd_valid), .i_rd_addr(i_rd_addr), .o_rd_ready(o_rd_ready),
    .o_rdq_valid(o_rdq_valid), .o_rdq_data(o_rdq_data), .i_rdq_ready(i_rdq_ready));
  dsr_sram_dev #(.DW(DW), .AW(AW), .NB(NB)) u_dsr_sram_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(lnk),
    .o_wr_busy(o_wr_busy), .o_rd_busy(o_rd_busy), .o_wr_beat(o_wr_beat), .o_sel_ignored(o_sel_ignored));
  // Read pins float while the device releases them
  assign rd_pins = lnk.rd_data_oe_n ? {DW{1'bz}} : lnk.rd_data;
  dsr_link_props #(.DW(DW), .AW(AW), .NB(NB)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .pos_phase(lnk.pos_phase), .addr(lnk.addr), .write_port_select_n(lnk.write_port_select_n),
    .read_port_select_n(lnk.read_port_select_n), .byte_write_mask_n(lnk.byte_write_mask_n),
    .wr_data(lnk.wr_data), .rd_data(lnk.rd_data), .rd_data_oe_n(lnk.rd_data_oe_n),
    .read_valid_flag(lnk.read_valid_flag), .echo_clock_out(lnk.echo_clock_out));

  // Unmasked nine-bit lanes take new data
  function automatic logic [BW-1:0] merge(input logic [BW-1:0] o, input logic [BW-1:0] d,
                                          input logic [4*NB-1:0] m);
    merge = o;
    for (int i = 0; i < 4 * NB; i++) begin
      if (!m[i]) begin
        merge[i*9 +: 9] = d[i*9 +: 9];
      end
    end
  endfunction : merge

  task automatic wr(input logic [AW-1:0] a, input logic [BW-1:0] d, input logic [4*NB-1:0] m);
    int n;
    n = 0;
    i_wr_valid = 1'b1;
    i_wr_addr = a;
    i_wr_data = d;
    i_wr_mask_n = m;
    shadow[a] = merge(shadow.exists(a) ? shadow[a] : '0, d, m);
    while (o_wr_ready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_wr_ready, 1'b1)
    @(negedge i_clk);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    int n;
    n = 0;
    i_rd_valid = 1'b1;
    i_rd_addr = a;
    while (o_rd_ready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_rd_ready, 1'b1)
    @(negedge i_clk);
  endtask : rd

  task automatic pop(input logic [BW-1:0] e);
    int n;
    n = 0;
    while (o_rdq_valid !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_rdq_valid, 1'b1)
    `CHK(o_rdq_data, e)
    i_rdq_ready = 1'b1;
    @(negedge i_clk);
    i_rdq_ready = 1'b0;
    @(negedge i_clk);
  endtask : pop

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    int n;
    n = 0;
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    `CHK(rd_pins, {DW{1'bz}})
    wr(6'h05, {36'h3_cccc_0003, 36'h2_bbbb_0002, 36'h1_aaaa_0001, 36'h0_9999_0000}, '0);
    wr(6'h09, {4{36'h6_0f0f_0f0f}}, '0);
    // Beat k drops lane k; last beat fully masked
    wr(6'h05, {4{36'h5_a5a5_a5a5}}, 16'hf421);
    i_wr_valid = 1'b0;
    // Last burst follows the previous one with no gap
    for (int j = 1; j <= 8; j++) begin
      @(negedge i_clk);
      `CHK(o_wr_busy, (j <= 4))
      `CHK(o_wr_beat, (j <= 5))
      `CHK(o_sel_ignored, 1'b0)
    end
    rd(6'h05);
    i_rd_valid = 1'b0;
    while (lnk.read_valid_flag !== 1'b1 && n < 10) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(lnk.read_valid_flag, 1'b1)
    for (int k = 0; k < 4; k++) begin
      `CHK(rd_pins, shadow[6'h05][k*DW +: DW])
      `CHK(o_rd_busy, (k < 3))
      @(negedge i_clk);
    end
    `CHK(rd_pins, {DW{1'bz}})
    pop(shadow[6'h05]);
    // Receiver stalls: two bursts fill the buffer
    rd(6'h09);
    rd(6'h05);
    i_rd_valid = 1'b0;
    repeat (12) begin
      @(negedge i_clk);
      `CHK(o_rd_ready, 1'b0)
    end
    pop(shadow[6'h09]);
    pop(shadow[6'h05]);
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge i_clk);
    error_cnt++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
